/* rtl/gpr_bank_pkg.sv */
// Behaviour
// - Bank follows the base pointer through RAM.
// - Bank accesses resolve only inside internal RAM.
// - Every word register supports single-bit access.
// - Word register n sits at base plus 2n.
// - Short addresses f0..ff select word registers 0..15.
// - Reset leaves word register contents untouched.
// - Only registers 0..7 allow byte access.
// - Byte write keeps the other byte intact.
// - Low byte at base+2n, high at base+2n+1.
// - Byte short addresses alternate low then high.
// - Reset leaves byte register contents untouched.
`default_nettype none

package gpr_bank_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Short address window and register layout.

   localparam logic [7:0]  SHORT_FIRST    = 8'hf0;
   localparam logic [4:0]  WORD_OFFSET [16] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                                5'h08, 5'h0a, 5'h0c, 5'h0e,
                                                5'h10, 5'h12, 5'h14, 5'h16,
                                                5'h18, 5'h1a, 5'h1c, 5'h1e};
   localparam logic [16:0] BANK_LAST_BYTE = 17'h0001f;

   ////////////////////////////////////////////////////////////////////////////////
   // Internal RAM bounds and base pointer reset value.

   localparam logic [15:0] IRAM_FIRST  = 16'h0000;
   localparam logic [15:0] IRAM_LAST   = 16'h07ff;
   localparam logic [15:0] BASE_RESET  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Access kinds.

   typedef enum logic [1:0] {ACC_WORD, ACC_BYTE, ACC_BIT} acc_kind_t;

   function automatic logic in_iram(input logic [15:0] a);
      return (a >= IRAM_FIRST) && (a <= IRAM_LAST);
   endfunction

endpackage

`default_nettype wire

/* rtl/gpr_addr_map.sv */
`timescale 1ns/1ns
`default_nettype none

module gpr_addr_map
   import gpr_bank_pkg::*;
(
   input  wire logic [15:0] base,
   input  wire logic        short_sel,
   input  wire acc_kind_t   kind,
   input  wire logic [15:0] addr,
   output logic      [15:0] phys,
   output logic             lane_hi,
   output logic             err
);

   logic        short_hit;
   logic [3:0]  idx;
   logic [4:0]  ofs_word;
   logic [4:0]  ofs_byte;
   logic [4:0]  ofs_sel;
   logic [15:0] phys_raw;
   logic [15:0] phys_last;
   logic [16:0] bank_end;
   logic        bank_ok;

   assign idx       = addr[3:0];
   assign short_hit = (addr[15:8] == 8'h00) && (addr[7:4] == SHORT_FIRST[7:4]);
   assign ofs_word  = WORD_OFFSET[idx];
   // Byte context pairs two short addresses onto one low word register.
   assign ofs_byte  = WORD_OFFSET[{1'b0, idx[3:1]}] | {4'h0, idx[0]};
   assign ofs_sel   = (kind == ACC_BYTE) ? ofs_byte : ofs_word;
   assign phys_raw  = short_sel ? base + {11'h000, ofs_sel} : addr;
   assign phys      = (kind == ACC_BYTE) ? phys_raw : {phys_raw[15:1], 1'b0};
   assign lane_hi   = (kind == ACC_BYTE) && phys_raw[0];
   assign phys_last = phys | {15'h0000, kind != ACC_BYTE};

   // A bank hanging over the top of the address space would wrap, so the
   // carry out of the end address disqualifies it as well.
   assign bank_end  = {1'b0, base} + BANK_LAST_BYTE;
   assign bank_ok   = in_iram(base) && !bank_end[16] && in_iram(bank_end[15:0]);

   assign err = (short_sel && (!short_hit || !bank_ok))
                || !in_iram(phys) || !in_iram(phys_last);

endmodule

`default_nettype wire

/* rtl/gpr_bit_merge.sv */
`timescale 1ns/1ns
`default_nettype none

module gpr_bit_merge
(
   input  wire logic [15:0] word,
   input  wire logic [3:0]  pos,
   input  wire logic        val,
   output logic      [15:0] merged,
   output logic             bit_out
);

   logic [15:0] mask;

   assign mask    = 16'h0001 << pos;
   assign merged  = val ? (word | mask) : (word & ~mask);
   assign bit_out = word[pos];

endmodule

`default_nettype wire

/* rtl/gpr_bank_ram_window.sv */
`timescale 1ns/1ns
`default_nettype none

module gpr_bank_ram_window
   import gpr_bank_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        base_wr,
   input  wire logic [15:0] base_wdata,
   output logic      [15:0] base_rdata,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire acc_kind_t   req_kind,
   input  wire logic        req_short,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   input  wire logic [3:0]  req_bit,
   output logic             rsp_valid,
   output logic      [15:0] rsp_rdata,
   output logic             rsp_error,
   output logic             ram_req,
   output logic             ram_we,
   output logic      [1:0]  ram_be,
   output logic      [15:0] ram_addr,
   output logic      [15:0] ram_wdata,
   input  wire logic [15:0] ram_rdata
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   typedef enum logic [1:0] {ST_IDLE, ST_RDWAIT, ST_RDDATA, ST_WRITE} state_t;

   state_t      state_r;
   state_t      state_nxt;
   logic [15:0] base_r;
   logic [15:0] base_nxt;
   logic        req_ready_r;
   logic        ready_nxt;
   logic        rsp_valid_r;
   logic        rsp_valid_nxt;
   logic [15:0] rsp_rdata_r;
   logic [15:0] rsp_rdata_nxt;
   logic        rsp_error_r;
   logic        rsp_error_nxt;
   logic        ram_req_r;
   logic        ram_req_nxt;
   logic        ram_we_r;
   logic        ram_we_nxt;
   logic [1:0]  ram_be_r;
   logic [1:0]  ram_be_nxt;
   logic [15:0] ram_addr_r;
   logic [15:0] ram_addr_nxt;
   logic [15:0] ram_wdata_r;
   logic [15:0] ram_wdata_nxt;
   acc_kind_t   kind_r;
   logic        write_r;
   logic        lane_r;
   logic [3:0]  bitpos_r;
   logic        bitval_r;

   logic        accept;
   logic        direct_write;
   logic [15:0] map_phys;
   logic        map_lane_hi;
   logic        map_err;
   logic [1:0]  be_sel;
   logic [15:0] wdata_sel;
   logic [15:0] merged_word;
   logic        picked_bit;
   logic [15:0] read_sel;
   logic [7:0]  byte_sel;
   logic [3:0]  short_idx;

   ////////////////////////////////////////////////////////////////////////////////
   // Address translation and bit handling.

   gpr_addr_map u_map (
      .base      (base_r),
      .short_sel (req_short),
      .kind      (req_kind),
      .addr      (req_addr),
      .phys      (map_phys),
      .lane_hi   (map_lane_hi),
      .err       (map_err)
   );

   gpr_bit_merge u_bit (
      .word    (ram_rdata),
      .pos     (bitpos_r),
      .val     (bitval_r),
      .merged  (merged_word),
      .bit_out (picked_bit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Request decode and data selection.

   assign accept       = req_valid && req_ready_r && (state_r == ST_IDLE);
   assign direct_write = req_write && (req_kind != ACC_BIT);
   assign short_idx    = req_addr[3:0];
   assign base_nxt     = base_wr ? {base_wdata[15:1], 1'b0} : base_r;

   // A byte write drives both lanes with the same byte and lets the enables
   // pick one, so the neighbouring byte in RAM is never rewritten.
   assign be_sel    = (req_kind != ACC_BYTE) ? 2'b11 :
                      (map_lane_hi ? 2'b10 : 2'b01);
   assign wdata_sel = (req_kind == ACC_BYTE) ? {req_wdata[7:0], req_wdata[7:0]}
                                             : req_wdata;
   assign byte_sel  = lane_r ? ram_rdata[15:8] : ram_rdata[7:0];
   assign read_sel  = (kind_r == ACC_WORD) ? ram_rdata :
                      (kind_r == ACC_BYTE) ? {8'h00, byte_sel} :
                                             {15'h0000, picked_bit};

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_comb
   begin
      state_nxt     = state_r;
      ready_nxt     = req_ready_r;
      rsp_valid_nxt = 1'b0;
      rsp_rdata_nxt = rsp_rdata_r;
      rsp_error_nxt = rsp_error_r;
      ram_req_nxt   = 1'b0;
      ram_we_nxt    = ram_we_r;
      ram_be_nxt    = ram_be_r;
      ram_addr_nxt  = ram_addr_r;
      ram_wdata_nxt = ram_wdata_r;
      case (state_r)
         ST_IDLE:
         begin
            if (accept && map_err)
            begin
               // Refused accesses never reach RAM.
               rsp_valid_nxt = 1'b1;
               rsp_error_nxt = 1'b1;
               rsp_rdata_nxt = 16'h0000;
            end
            else if (accept)
            begin
               ram_req_nxt   = 1'b1;
               ram_we_nxt    = direct_write;
               ram_be_nxt    = be_sel;
               ram_addr_nxt  = map_phys;
               ram_wdata_nxt = wdata_sel;
               ready_nxt     = 1'b0;
               state_nxt     = direct_write ? ST_WRITE : ST_RDWAIT;
            end
         end
         ST_RDWAIT:
         begin
            state_nxt = ST_RDDATA;
         end
         ST_RDDATA:
         begin
            if ((kind_r == ACC_BIT) && write_r)
            begin
               // Bit writes are a read-modify-write of the whole word.
               ram_req_nxt   = 1'b1;
               ram_we_nxt    = 1'b1;
               ram_be_nxt    = 2'b11;
               ram_wdata_nxt = merged_word;
               state_nxt     = ST_WRITE;
            end
            else
            begin
               rsp_valid_nxt = 1'b1;
               rsp_error_nxt = 1'b0;
               rsp_rdata_nxt = read_sel;
               ready_nxt     = 1'b1;
               state_nxt     = ST_IDLE;
            end
         end
         ST_WRITE:
         begin
            rsp_valid_nxt = 1'b1;
            rsp_error_nxt = 1'b0;
            rsp_rdata_nxt = 16'h0000;
            ready_nxt     = 1'b1;
            state_nxt     = ST_IDLE;
         end
         default:
         begin
            ready_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State registers. Register contents live in RAM, so reset only clears
   // the sequencer and the base pointer and never issues a RAM cycle.

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r     <= ST_IDLE;
         base_r      <= BASE_RESET;
         req_ready_r <= 1'b1;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
         rsp_error_r <= 1'b0;
         ram_req_r   <= 1'b0;
         ram_we_r    <= 1'b0;
         ram_be_r    <= 2'b00;
         ram_addr_r  <= 16'h0000;
         ram_wdata_r <= 16'h0000;
      end
      else if (ce)
      begin
         state_r     <= state_nxt;
         base_r      <= base_nxt;
         req_ready_r <= ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_rdata_r <= rsp_rdata_nxt;
         rsp_error_r <= rsp_error_nxt;
         ram_req_r   <= ram_req_nxt;
         ram_we_r    <= ram_we_nxt;
         ram_be_r    <= ram_be_nxt;
         ram_addr_r  <= ram_addr_nxt;
         ram_wdata_r <= ram_wdata_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         kind_r   <= ACC_WORD;
         write_r  <= 1'b0;
         lane_r   <= 1'b0;
         bitpos_r <= 4'h0;
         bitval_r <= 1'b0;
      end
      else if (ce && accept)
      begin
         kind_r   <= req_kind;
         write_r  <= req_write;
         lane_r   <= map_lane_hi;
         bitpos_r <= req_bit;
         bitval_r <= req_wdata[0];
      end
   end

   assign base_rdata = base_r;
   assign req_ready  = req_ready_r;
   assign rsp_valid  = rsp_valid_r;
   assign rsp_rdata  = rsp_rdata_r;
   assign rsp_error  = rsp_error_r;
   assign ram_req    = ram_req_r;
   assign ram_we     = ram_we_r;
   assign ram_be     = ram_be_r;
   assign ram_addr   = ram_addr_r;
   assign ram_wdata  = ram_wdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks. They assume the clock enable stays high while they are sampled.

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n || !ce);

   sequence take_s(acc_kind_t k, logic wr, logic sh);
      accept && !map_err && (req_kind == k) && (req_write == wr) && (req_short == sh);
   endsequence

   sequence rmw_write_s;
      ##3 (ram_req_r && ram_we_r && (ram_be_r == 2'b11));
   endsequence

   sequence rsp_ok_s;
      rsp_valid_r && !rsp_error_r;
   endsequence

   bank_window_a: assert property (
      (accept && !map_err && req_short) |=>
         (ram_req_r && ((ram_addr_r - $past(base_r)) <= 16'h001f)))
      else $error("short access fell outside the bank window");

   iram_only_a: assert property (
      ram_req_r |-> (in_iram(ram_addr_r) && in_iram(ram_addr_r | 16'h0001)))
      else $error("RAM cycle issued outside internal RAM");

   bit_rmw_a: assert property (
      take_s(ACC_BIT, 1'b1, req_short) |-> rmw_write_s ##1 rsp_ok_s)
      else $error("bit write did not finish as read-modify-write");

   bit_only_a: assert property (
      (ram_req_r && ram_we_r && (state_r == ST_WRITE) && ($past(state_r) == ST_RDDATA))
         |-> (((ram_wdata_r ^ $past(ram_rdata)) & ~(16'h0001 << bitpos_r)) == 16'h0000))
      else $error("bit write disturbed other bits");

   word_addr_a: assert property (
      take_s(ACC_WORD, req_write, 1'b1) |=>
         (ram_addr_r == ($past(base_r) + {11'h000, $past(short_idx), 1'b0})))
      else $error("word register address is not base plus twice the index");

   short_miss_a: assert property (
      (accept && req_short && (req_addr[7:4] != SHORT_FIRST[7:4]))
         |=> (rsp_valid_r && rsp_error_r && !ram_req_r))
      else $error("short address outside the window was not refused");

   no_spont_wr_a: assert property (
      (ram_req_r && ram_we_r) |-> ($past(accept) || ($past(state_r) == ST_RDDATA)))
      else $error("RAM write issued without a request");

   byte_low_a: assert property (
      take_s(ACC_BYTE, req_write, 1'b1) |=> ((ram_addr_r - $past(base_r)) <= 16'h000f))
      else $error("byte access reached beyond the lower eight registers");

   byte_lane_a: assert property (
      take_s(ACC_BYTE, 1'b1, req_short) |=> (ram_we_r && $onehot(ram_be_r)))
      else $error("byte write enabled both lanes");

   byte_map_a: assert property (
      take_s(ACC_BYTE, req_write, 1'b1) |=>
         ((ram_addr_r == ($past(base_r) + {12'h000, $past(short_idx)}))
          && (ram_be_r[1] == $past(short_idx[0]))))
      else $error("byte short address mapped to the wrong lane or word");

   word_read_a: assert property (
      take_s(ACC_WORD, 1'b0, req_short) |-> ##3 (rsp_ok_s and (rsp_rdata_r == $past(ram_rdata))))
      else $error("word read did not return the RAM word as is");

endmodule

`default_nettype wire

/* tb/iram_model.sv */
`timescale 1ns/1ns
`default_nettype none

module iram_model
(
   input  wire logic        clock,
   input  wire logic        ram_req,
   input  wire logic        ram_we,
   input  wire logic [1:0]  ram_be,
   input  wire logic [15:0] ram_addr,
   input  wire logic [15:0] ram_wdata,
   output logic      [15:0] ram_rdata
);
   logic [7:0]  mem [2048];
   logic [10:0] lo;
   logic [10:0] hi;

   assign lo = {ram_addr[10:1], 1'b0};
   assign hi = {ram_addr[10:1], 1'b1};

   initial
   begin
      foreach (mem[i]) mem[i] = 8'h00;
   end

   // Read data is good for one cycle only; afterwards it toggles so stale use shows.
   always @(posedge clock)
   begin
      if (ram_req && ram_we && ram_be[0]) mem[lo] <= ram_wdata[7:0];
      if (ram_req && ram_we && ram_be[1]) mem[hi] <= ram_wdata[15:8];
      if (ram_req && !ram_we) ram_rdata <= {mem[hi], mem[lo]};
      else ram_rdata <= ~ram_rdata;
   end
endmodule

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb
   import gpr_bank_pkg::*;
;
   logic clock, rst_n, base_wr, req_valid, req_ready, req_write, req_short;
   logic rsp_valid, rsp_error, ram_req, ram_we;
   logic [1:0] ram_be;
   logic [3:0] req_bit;
   logic [15:0] base_wdata, base_rdata, req_addr, req_wdata, rsp_rdata;
   logic [15:0] ram_addr, ram_wdata, ram_rdata, base_model;
   acc_kind_t req_kind;
   logic [7:0] ref_mem [2048];
   int miscompares, total_checks, cycles;

   gpr_bank_ram_window i_gpr_bank_ram_window (.clock(clock), .rst_n(rst_n), .ce(1'b1),
      .base_wr(base_wr), .base_wdata(base_wdata), .base_rdata(base_rdata),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_kind(req_kind), .req_short(req_short), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_bit(req_bit), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .ram_req(ram_req), .ram_we(ram_we),
      .ram_be(ram_be), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

   iram_model i_iram_model (.clock(clock), .ram_req(ram_req), .ram_we(ram_we),
      .ram_be(ram_be), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         conclude();
      end
   end

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic set_base(input logic [15:0] v);
      @(posedge clock);
      base_wr <= 1'b1;
      base_wdata <= v;
      @(posedge clock);
      base_wr <= 1'b0;
      base_model = v & 16'hfffe;
      #1 check16(base_rdata, base_model);
   endtask

   // Works out address, refusal, data and latency, then runs one request.
   task automatic do_op(input logic w, input acc_kind_t k, input logic s,
                        input logic [15:0] a, input logic [15:0] d, input logic [3:0] b);
      logic [16:0] p;
      logic [10:0] i;
      logic [15:0] cur, exp_d;
      logic e;
      int lat, n;
      if (s) p = {1'b0, base_model} + ((k == ACC_BYTE) ? 17'(a[3:0]) : 17'({a[3:0], 1'b0}));
      else p = (k == ACC_BYTE) ? {1'b0, a} : {1'b0, a[15:1], 1'b0};
      if (s) e = (a[15:4] != 12'h00f) || ({1'b0, base_model} + 17'h1f > 17'h7ff);
      else e = p + ((k == ACC_BYTE) ? 17'h0 : 17'h1) > 17'h7ff;
      i = p[10:0];
      cur = {ref_mem[i + 11'd1], ref_mem[i]};
      lat = e ? 1 : w ? ((k == ACC_BIT) ? 4 : 2) : 3;
      exp_d = (e || w) ? 16'h0000 : (k == ACC_WORD) ? cur :
              (k == ACC_BYTE) ? {8'h00, cur[7:0]} : {15'h0, cur[b]};
      if (w && !e && k != ACC_BYTE) ref_mem[i + 11'd1] = (k == ACC_WORD) ? d[15:8] :
         (b > 4'd7) ? (cur[15:8] & ~(8'h01 << (b - 4'd8))) | ({7'h0, d[0]} << (b - 4'd8)) :
         cur[15:8];
      if (w && !e) ref_mem[i] = (k != ACC_BIT) ? d[7:0] : (b > 4'd7) ? cur[7:0] :
         (cur[7:0] & ~(8'h01 << b)) | ({7'h0, d[0]} << b);
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_kind <= k;
      req_short <= s;
      req_addr <= a;
      req_wdata <= d;
      req_bit <= b;
      @(posedge clock);
      req_valid <= 1'b0;
      // The answer can stand in the very cycle after the taking edge, so the
      // first look is one step after that edge and counts as latency one.
      n = 1;
      #1;
      while (rsp_valid !== 1'b1 && n < 8)
      begin
         @(posedge clock);
         #1 n++;
      end
      check16(16'(n), 16'(lat));
      check16({15'h0, rsp_error}, {15'h0, e});
      check16(rsp_rdata, exp_d);
   endtask

   initial
   begin
      rst_n = 1'b0;
      base_wr = 1'b0;
      base_wdata = 16'h0000;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_kind = ACC_WORD;
      req_short = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 16'h0000;
      req_bit = 4'h0;
      base_model = BASE_RESET;
      foreach (ref_mem[j]) ref_mem[j] = 8'h00;
      void'($urandom(32'hda7216f3));
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      #1 check16(base_rdata, 16'h0000);
      check16({15'h0, req_ready}, 16'h0001);

      set_base(16'h0101);
      for (int n = 0; n < 16; n++) do_op(1'b1, ACC_WORD, 1'b1, 16'(8'hf0 + n), 16'($urandom), 4'h0);
      for (int n = 0; n < 16; n++) do_op(1'b0, ACC_WORD, 1'b0, 16'h0100 + 16'(2 * n), 16'h0, 4'h0);
      for (int k = 0; k < 16; k++) do_op(1'b0, ACC_BYTE, 1'b1, 16'(8'hf0 + k), 16'h0, 4'h0);
      $display("test word and byte map done");

      for (int k = 0; k < 16; k += 3) do_op(1'b1, ACC_BYTE, 1'b1, 16'(8'hf0 + k), 16'($urandom), 4'h0);
      for (int n = 0; n < 8; n++) do_op(1'b0, ACC_WORD, 1'b1, 16'(8'hf0 + n), 16'h0, 4'h0);
      for (int n = 0; n < 16; n++)
      begin
         do_op(1'b1, ACC_BIT, 1'b1, 16'(8'hf0 + n), 16'($urandom), 4'($urandom));
         do_op(1'b0, ACC_BIT, 1'b1, 16'(8'hf0 + n), 16'h0, 4'(n));
         do_op(1'b0, ACC_WORD, 1'b1, 16'(8'hf0 + n), 16'h0, 4'h0);
      end
      $display("test byte and bit writes done");

      set_base(16'h07e0);
      for (int n = 0; n < 16; n++) do_op(1'b1, ACC_WORD, 1'b1, 16'(8'hf0 + n), 16'($urandom), 4'h0);
      for (int n = 0; n < 16; n++) do_op(1'b0, ACC_WORD, 1'b0, 16'h0100 + 16'(2 * n), 16'h0, 4'h0);
      $display("test relocation done");

      set_base(16'h07e2);
      do_op(1'b0, ACC_WORD, 1'b1, 16'h00f0, 16'h0, 4'h0);
      do_op(1'b1, ACC_BYTE, 1'b0, 16'h0800, 16'h00aa, 4'h0);
      do_op(1'b0, ACC_BYTE, 1'b0, 16'h07ff, 16'h0, 4'h0);
      set_base(16'h0000);
      do_op(1'b0, ACC_WORD, 1'b1, 16'h00ef, 16'h0, 4'h0);
      do_op(1'b1, ACC_WORD, 1'b1, 16'h01f0, 16'h1234, 4'h0);
      $display("test refusals done");

      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      base_model = BASE_RESET;
      #1 check16(base_rdata, BASE_RESET);
      set_base(16'h07e0);
      for (int n = 0; n < 16; n++) do_op(1'b0, ACC_WORD, 1'b1, 16'(8'hf0 + n), 16'h0, 4'h0);
      for (int k = 0; k < 16; k++) do_op(1'b0, ACC_BYTE, 1'b1, 16'(8'hf0 + k), 16'h0, 4'h0);
      $display("test reset keeps contents done");

      for (int t = 0; t < 200; t++)
      begin
         if (t % 25 == 0) set_base(16'($urandom_range(0, 16'h07f0)));
         do_op(1'($urandom), acc_kind_t'($urandom_range(0, 2)), 1'($urandom),
               ($urandom_range(0, 7) == 0) ? 16'($urandom_range(0, 16'h0900)) :
               16'(8'hf0 + $urandom_range(0, 15)), 16'($urandom), 4'($urandom));
      end
      $display("test random traffic done");
      conclude();
   end
endmodule

`default_nettype wire
